/* design/ird_pkg.sv */
// shared constants and types for the i2c rate reload and diagnostics block
package ird_pkg;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_RATE_HIGH = 12'hf53;
  localparam logic [11:0] IDX_RATE_LOW = 12'hf54;
  localparam logic [11:0] IDX_BUS_STATE = 12'hf55;
  localparam logic [11:0] IDX_COUNTER_READBACK_SELECT_CTRL = 12'hf56;
  localparam int unsigned ADDR_W = 14;

  // reset values
  localparam logic [7:0] RELOAD_HIGH_RST = 8'hff;
  localparam logic [7:0] RELOAD_LOW_RST = 8'hff;
  localparam logic [7:0] COUNTER_READBACK_SELECT_CTRL_RST = 8'h00;

  // field positions
  localparam int unsigned COUNTER_READBACK_SELECT_SEL_BIT = 0;
  localparam int unsigned DST_SCL_BIT = 7;
  localparam int unsigned DST_SDA_BIT = 6;
  localparam int unsigned DST_STOP_BIT = 5;

  // rate counter reloads when it has counted down to this value
  localparam logic [15:0] RATE_CNT_LAST = 16'h0001;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // transfer state codes
  typedef enum logic [4:0] {
    ST_IDLE = 5'h00,
    ST_START = 5'h01,
    ST_DATA7 = 5'h02,
    ST_DATA0 = 5'h09,
    ST_DATA_ACK = 5'h0a,
    ST_DATA_NACK = 5'h0b,
    ST_STOP1 = 5'h0c,
    ST_STOP2 = 5'h0d,
    ST_ADDR_ACK = 5'h0e,
    ST_ADDR_BIT0 = 5'h0f,
    ST_XA_BIT7 = 5'h10,
    ST_XA_BIT1 = 5'h16,
    ST_XA_RW = 5'h17,
    ST_XA_ACK = 5'h18,
    ST_ADDR_BIT7 = 5'h19,
    ST_ADDR_BIT1 = 5'h1f
  } ird_state_t;

endpackage

/* design/ird_rate_counter_readback_select.sv */
// rate reload storage, rate counter, transfer state tracker and diagnostic readback
// Operation
// [R1] high and low bytes form 16-bit reload
// [R2] high byte is reload bits 15..8
// [R3] low byte is bits 7..0, resets ff
// [R4] select=1: high read returns counter 15..8
// [R5] select=1: low read returns counter 7..0
// [R6] select=0: both reads return stored reload
// [R7] diagnostic control register is read/write, holds select
// [R8] observe register read-only; bit7 clock, bit6 data
// [R9] observe bit 5 shows stop count
// [R10] idle 00, start 01, data 02..09
// [R11] data ack 0a, nack half 0b
// [R12] stop in two states 0c, 0d
// [R13] 7-bit address 19..1f, rw 0f, ack 0e
// [R14] 10-bit first byte 10..16, rw 17
// [R15] 10-bit first byte ack in 18
// [R16] 10-bit second byte 19..1f, 0f, 0e
// [R17] select at bit 0, resets 0, rest zero
// [R18] snapshot sampled on clk for stable reads
//
// Local design decision: the AXI4-Lite register port.
module ird_rate_counter_readback_select
  import ird_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic [15:0] rate_reload,
  output logic rate_tick,
  input wire logic link_clk,
  input wire logic link_reset_n,
  input wire logic link_step,
  input wire logic link_start,
  input wire logic link_stop,
  input wire logic link_nack,
  input wire logic link_ten_bit,
  input wire logic link_stop_count,
  output logic [4:0] link_state
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // link domain: transfer state tracker
  ird_state_t lk_state_q;
  ird_state_t lk_state_d;
  logic [5:0] lk_snap_q;
  logic lk_req_q;
  logic lk_ack_s;

  // next state on each bit step
  always_comb begin
    lk_state_d = lk_state_q;
    if (link_step) begin
      unique case (lk_state_q)
        ST_IDLE: lk_state_d = link_start ? ST_START : ST_IDLE; // see [R10]
        ST_START: lk_state_d = link_ten_bit ? ST_XA_BIT7 : ST_ADDR_BIT7; // see [R13] see [R14]
        ST_XA_BIT1: lk_state_d = ST_XA_RW; // see [R14]
        ST_XA_RW: lk_state_d = ST_XA_ACK; // see [R15]
        ST_XA_ACK: lk_state_d = ST_ADDR_BIT7; // see [R16]
        ST_ADDR_BIT1: lk_state_d = ST_ADDR_BIT0; // see [R13] see [R16]
        ST_ADDR_BIT0: lk_state_d = ST_ADDR_ACK;
        ST_ADDR_ACK: lk_state_d = (link_nack || link_stop) ? ST_STOP1 : ST_DATA7;
        ST_DATA0: lk_state_d = ST_DATA_ACK; // see [R10]
        ST_DATA_ACK: begin
          if (link_nack) begin
            lk_state_d = ST_DATA_NACK; // see [R11]
          end else if (link_stop) begin
            lk_state_d = ST_STOP1;
          end else if (link_start) begin
            lk_state_d = ST_START;
          end else begin
            lk_state_d = ST_DATA7;
          end
        end
        ST_DATA_NACK: lk_state_d = link_start ? ST_START : ST_STOP1; // see [R11]
        ST_STOP1: lk_state_d = ST_STOP2; // see [R12]
        ST_STOP2: lk_state_d = ST_IDLE; // see [R12]
        // remaining codes are the inner bits of a byte: step to the next code
        default: lk_state_d = ird_state_t'(lk_state_q + 5'h01);
      endcase
    end
  end

  // state register on the link clock
  always_ff @(posedge link_clk) begin
    if (!link_reset_n) begin
      lk_state_q <= ST_IDLE;
    end else begin
      lk_state_q <= lk_state_d;
    end
  end

  assign link_state = lk_state_q;

  // handshake source: data held while a request is open
  always_ff @(posedge link_clk) begin
    if (!link_reset_n) begin
      lk_snap_q <= 6'h00;
      lk_req_q <= 1'b0;
    end else if (lk_req_q == lk_ack_s) begin
      lk_snap_q <= {link_stop_count, lk_state_q}; // see [R9]
      lk_req_q <= ~lk_req_q;
    end
  end

  // crossings between the two clocks and from the pins
  logic ack_q;
  logic req_s;
  logic scl_s;
  logic sda_s;
  ird_sync_if #(.W(1)) ack_if ();
  ird_sync_if #(.W(1)) req_if ();
  ird_sync_if #(.W(2)) pin_if ();

  assign ack_if.din = ack_q;
  assign lk_ack_s = ack_if.dout;
  assign req_if.din = lk_req_q;
  assign req_s = req_if.dout;
  assign pin_if.din = {scl_in, sda_in};
  assign scl_s = pin_if.dout[1];
  assign sda_s = pin_if.dout[0];

  ird_sync #(.W(1)) u_ack_sync (.clk(link_clk), .port(ack_if));
  ird_sync #(.W(1)) u_req_sync (.clk(clk), .port(req_if));
  ird_sync #(.W(2)) u_pin_sync (.clk(clk), .port(pin_if));

  // clk domain: snapshot of link state
  logic [5:0] snap_q;

  // lk_snap_q is stable while req and ack differ, so it is safe to take here
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      snap_q <= 6'h00;
      ack_q <= 1'b0;
    end else if (ce && (req_s != ack_q)) begin
      snap_q <= lk_snap_q; // see [R18]
      ack_q <= req_s;
    end
  end

  // software visible registers
  logic [7:0] reload_high_q;
  logic [7:0] reload_low_q;
  logic counter_readback_select_sel_q;
  logic [15:0] cnt_q;

  assign rate_reload = {reload_high_q, reload_low_q}; // see [R1] see [R2] see [R3]

  // rate counter
  // counts down each enabled cycle and reloads after reaching one
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_q <= {RELOAD_HIGH_RST, RELOAD_LOW_RST};
      rate_tick <= 1'b0;
    end else if (ce) begin
      rate_tick <= (cnt_q <= RATE_CNT_LAST);
      if (cnt_q <= RATE_CNT_LAST) begin
        cnt_q <= rate_reload; // see [R1]
      end else begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end

  // axi write channel
  logic aw_held_q;
  logic w_held_q;
  logic [11:0] aw_idx_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic wr_go;
  logic [11:0] wr_idx;
  logic wr_hit;

  // address and data are taken in either order; no new pair while a response waits
  assign s_axi_awready = ce && !aw_held_q && !bvalid_q;
  assign s_axi_wready = ce && !w_held_q && !bvalid_q;
  assign wr_go = ce && aw_held_q && w_held_q && !bvalid_q;
  assign wr_idx = aw_idx_q;
  assign wr_hit = (wr_idx == IDX_RATE_HIGH) || (wr_idx == IDX_RATE_LOW)
    || (wr_idx == IDX_BUS_STATE) || (wr_idx == IDX_COUNTER_READBACK_SELECT_CTRL);

  // capture write address and data
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_idx_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[ADDR_W-1:2];
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // write response; unmapped index answers slverr
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // register writes; observe register ignores writes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reload_high_q <= RELOAD_HIGH_RST;
      reload_low_q <= RELOAD_LOW_RST; // see [R3]
      counter_readback_select_sel_q <= COUNTER_READBACK_SELECT_CTRL_RST[COUNTER_READBACK_SELECT_SEL_BIT]; // see [R17]
    end else if (wr_go && wstrb_q[0]) begin
      if (wr_idx == IDX_RATE_HIGH) begin
        reload_high_q <= wdata_q[7:0]; // see [R2]
      end
      if (wr_idx == IDX_RATE_LOW) begin
        reload_low_q <= wdata_q[7:0]; // see [R3]
      end
      if (wr_idx == IDX_COUNTER_READBACK_SELECT_CTRL) begin
        counter_readback_select_sel_q <= wdata_q[COUNTER_READBACK_SELECT_SEL_BIT]; // see [R7] see [R17]
      end
    end
  end

  // axi read channel
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [11:0] rd_idx;
  logic [7:0] rd_byte;
  logic rd_hit;

  assign s_axi_arready = ce && !rvalid_q;
  assign rd_idx = s_axi_araddr[ADDR_W-1:2];

  // read multiplexer; select bit swaps reload for live counter
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    unique case (rd_idx)
      IDX_RATE_HIGH: rd_byte = counter_readback_select_sel_q ? cnt_q[15:8] : reload_high_q; // see [R4] see [R6]
      IDX_RATE_LOW: rd_byte = counter_readback_select_sel_q ? cnt_q[7:0] : reload_low_q; // see [R5] see [R6]
      IDX_BUS_STATE: rd_byte = {scl_s, sda_s, snap_q}; // see [R8] see [R9]
      IDX_COUNTER_READBACK_SELECT_CTRL: rd_byte = {7'h00, counter_readback_select_sel_q}; // see [R17]
      default: rd_hit = 1'b0;
    endcase
  end

  // data held in a register, so the value read cannot change under the master
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rdata_q <= {24'h00_0000, rd_byte}; // see [R18]
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // checks
  logic rd_take;
  assign rd_take = s_axi_arvalid && s_axi_arready;

  sequence rd_of(logic [11:0] idx);
    rd_take && (rd_idx == idx);
  endsequence

  reload_cat_a: assert property (wr_go && wstrb_q[0] // see [R1] see [R3]
    && wr_idx == IDX_RATE_LOW |=> rate_reload == {$past(reload_high_q), $past(wdata_q[7:0])})
    else $error("reload byte write lost");
  high_write_a: assert property (wr_go && wstrb_q[0] && wr_idx == IDX_RATE_HIGH // see [R2]
    |=> rate_reload[15:8] == $past(wdata_q[7:0]))
    else $error("high reload byte not in bits 15..8");
  high_counter_readback_select_a: assert property (rd_of(IDX_RATE_HIGH) ##0 counter_readback_select_sel_q // see [R4]
    |=> s_axi_rvalid && s_axi_rdata == {24'h00_0000, $past(cnt_q[15:8])})
    else $error("high read missed counter");
  low_counter_readback_select_a: assert property (rd_of(IDX_RATE_LOW) ##0 counter_readback_select_sel_q // see [R5]
    |=> s_axi_rdata[7:0] == $past(cnt_q[7:0]))
    else $error("low read missed counter");
  normal_read_a: assert property (rd_of(IDX_RATE_LOW) ##0 !counter_readback_select_sel_q // see [R6]
    |=> s_axi_rdata[7:0] == $past(reload_low_q))
    else $error("normal read not reload");
  counter_readback_select_ctrl_a: assert property (rd_of(IDX_COUNTER_READBACK_SELECT_CTRL) // see [R7] see [R17]
    |=> s_axi_rdata == {31'h0000_0000, $past(counter_readback_select_sel_q)})
    else $error("counter_readback_select control readback wrong");
  bus_state_a: assert property (rd_of(IDX_BUS_STATE) // see [R8]
    |=> s_axi_rdata[DST_SCL_BIT] == $past(scl_s) && s_axi_rdata[DST_SDA_BIT] == $past(sda_s))
    else $error("observed pin bits wrong");
  cnt_reload_a: assert property (ce && cnt_q == RATE_CNT_LAST // see [R1]
    |=> cnt_q == $past(rate_reload))
    else $error("counter did not reload");

  sequence stop_first;
    lk_state_q == ST_STOP1 && link_step;
  endsequence
  stop_pair_a: assert property ( // see [R12]
    @(posedge link_clk) disable iff (!link_reset_n)
    stop_first |=> lk_state_q == ST_STOP2 ##0 (!link_step or ##1 lk_state_q == ST_IDLE))
    else $error("stop not two states");
  start_seq_a: assert property ( // see [R10]
    @(posedge link_clk) disable iff (!link_reset_n)
    lk_state_q == ST_IDLE && link_step && link_start |=> lk_state_q == ST_START)
    else $error("start state missed");
  nack_half_a: assert property ( // see [R11]
    @(posedge link_clk) disable iff (!link_reset_n)
    lk_state_q == ST_DATA_ACK && link_step && link_nack |=> lk_state_q == ST_DATA_NACK)
    else $error("nack half missed");
  addr_path_a: assert property ( // see [R13] see [R14]
    @(posedge link_clk) disable iff (!link_reset_n)
    lk_state_q == ST_START && link_step |=>
    lk_state_q == ($past(link_ten_bit) ? ST_XA_BIT7 : ST_ADDR_BIT7))
    else $error("address start code wrong");
  xa_ack_a: assert property ( // see [R15] see [R16]
    @(posedge link_clk) disable iff (!link_reset_n)
    lk_state_q == ST_XA_RW && link_step |=> lk_state_q == ST_XA_ACK
    ##0 (!link_step or ##1 lk_state_q == ST_ADDR_BIT7))
    else $error("first address ack wrong");

endmodule

/* design/ird_sync.sv */
// two-stage synchroniser into the domain of clk
module ird_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  ird_sync_if.sync port
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    meta_q <= port.din;
    sync_q <= meta_q;
  end

  assign port.dout = sync_q;
endmodule

/* design/ird_sync_if.sv */
// carrier between a synchroniser and its user
interface ird_sync_if #(
  parameter int unsigned W = 1
);
  logic [W-1:0] din;
  logic [W-1:0] dout;
  modport sync (input din, output dout);
  modport user (output din, input dout);
endinterface

/* verif/ird_bus_partner.sv */
// bus partner model: open-drain clock and data lines with pull-ups
module ird_bus_partner (
  input wire logic hold_scl_low,
  input wire logic hold_sda_low,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released line floats up to the pull-up level, never to its last value
  assign scl = hold_scl_low ? 1'b0 : 1'b1;
  assign sda = hold_sda_low ? 1'b0 : 1'b1;
endmodule

/* verif/ird_rate_counter_readback_select_tb.sv */
// self-checking bench for the rate reload and diagnostics block
module ird_rate_counter_readback_select_tb;
  import ird_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, ce, link_clk, link_reset_n;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic scl, sda, hold_scl, hold_sda, rate_tick;
  logic [15:0] rate_reload;
  logic step, start, stop, nack, ten_bit, stop_cnt;
  logic [4:0] link_state;
  logic [7:0] d, d2;
  int bad_count, num_checks, n;

  ird_rate_counter_readback_select ird_rate_counter_readback_select_i (
    .clk(clk), .reset_n(reset_n), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .scl_in(scl), .sda_in(sda), .rate_reload(rate_reload), .rate_tick(rate_tick),
    .link_clk(link_clk), .link_reset_n(link_reset_n), .link_step(step),
    .link_start(start), .link_stop(stop), .link_nack(nack), .link_ten_bit(ten_bit),
    .link_stop_count(stop_cnt), .link_state(link_state)
  );

  ird_bus_partner ird_bus_partner_i (
    .hold_scl_low(hold_scl), .hold_sda_low(hold_sda), .scl(scl), .sda(sda)
  );

  // system clock, and a link clock with an unrelated phase
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #32 link_clk = ~link_clk;
  end

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic give_up();
    chk("handshake", 32'h1, 32'h0);
    summarize();
  endtask

  // one write; valids are held until their own ready is seen
  task automatic wr(input logic [11:0] idx, input logic [7:0] v, input logic [3:0] st,
                    input logic [1:0] er);
    logic [1:0] r;
    @(posedge clk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, v};
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        break;
      end
    end
    bready <= 1'b0;
    if (n == 100) give_up();
    chk("bresp", er, r);
  endtask

  // one read; data and response are taken at the edge that shows rvalid
  task automatic rdr(input logic [11:0] idx, input logic [1:0] er, output logic [7:0] v);
    logic [31:0] x;
    logic [1:0] r;
    @(posedge clk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        x = rdata;
        r = rresp;
        break;
      end
    end
    rready <= 1'b0;
    if (n == 100) give_up();
    chk("rresp", er, r);
    chk("rdata upper", 32'h0, {8'h0, x[31:8]});
    v = x[7:0];
  endtask

  task automatic rchk(input logic [11:0] idx, input logic [7:0] exp, input string nm);
    rdr(idx, RESP_OKAY, d);
    chk(nm, exp, d);
  endtask

  // one state step: step is offered for a single link edge
  task automatic lstep(input logic st, input logic sp, input logic nk, input logic [4:0] exp);
    @(posedge link_clk);
    start <= st;
    stop <= sp;
    nack <= nk;
    step <= 1'b1;
    @(posedge link_clk);
    step <= 1'b0;
    #1 chk("link_state", exp, link_state);
  endtask

  task automatic lrun(input logic [4:0] first, input int cnt);
    for (int i = 0; i < cnt; i++) lstep(1'b0, 1'b0, 1'b0, 5'(first + i));
  endtask

  task automatic t_reset();
    rchk(IDX_RATE_HIGH, 8'hff, "high reset");
    rchk(IDX_RATE_LOW, 8'hff, "low reset");
    rchk(IDX_COUNTER_READBACK_SELECT_CTRL, 8'h00, "select reset");
    chk("reload", 32'hffff, rate_reload);
    chk("state idle", 32'h0, link_state);
  endtask

  // reload of 16 gives one tick every 16 cycles; partial strobe stores nothing
  task automatic t_rate();
    wr(IDX_RATE_LOW, 8'h10, 4'hf, RESP_OKAY);
    wr(IDX_RATE_HIGH, 8'h00, 4'hf, RESP_OKAY);
    chk("reload", 32'h0010, rate_reload);
    wr(IDX_RATE_LOW, 8'h55, 4'he, RESP_OKAY);
    rchk(IDX_RATE_LOW, 8'h10, "low kept");
    for (n = 0; n < 70000 && rate_tick !== 1'b1; n++) @(posedge clk);
    if (n == 70000) give_up();
    for (n = 1; n < 100; n++) begin
      @(posedge clk);
      if (rate_tick === 1'b1) break;
    end
    chk("tick period", 32'd16, n);
    // four frozen cycles push the next tick four cycles later
    ce <= 1'b0;
    repeat (4) @(posedge clk);
    ce <= 1'b1;
    for (n = 1; n < 100; n++) begin
      @(posedge clk);
      if (rate_tick === 1'b1) break;
    end
    chk("frozen period", 32'd16, n);
    wr(12'hf57, 8'h01, 4'hf, RESP_SLVERR);
    rdr(12'hf57, RESP_SLVERR, d);
    chk("unmapped", 32'h0, d);
  endtask

  task automatic t_counter_readback_select();
    wr(IDX_COUNTER_READBACK_SELECT_CTRL, 8'hff, 4'hf, RESP_OKAY);
    rchk(IDX_COUNTER_READBACK_SELECT_CTRL, 8'h01, "select");
    rchk(IDX_RATE_HIGH, 8'h00, "counter high");
    rdr(IDX_RATE_LOW, RESP_OKAY, d);
    rdr(IDX_RATE_LOW, RESP_OKAY, d2);
    chk("counter low", 32'h1, d >= 1 && d <= 16 && (d != 16 || d2 != 16));
    // the two reads are taken three cycles apart on a counter of period 16
    chk("counter low next", (d > 8'd3) ? d - 8'd3 : d + 8'd13, d2);
    wr(IDX_COUNTER_READBACK_SELECT_CTRL, 8'h00, 4'hf, RESP_OKAY);
    wr(IDX_RATE_HIGH, 8'h7f, 4'hf, RESP_OKAY);
    rchk(IDX_RATE_HIGH, 8'h7f, "stored high");
    rchk(IDX_RATE_LOW, 8'h10, "stored low");
    chk("reload", 32'h7f10, rate_reload);
    wr(IDX_COUNTER_READBACK_SELECT_CTRL, 8'h01, 4'hf, RESP_OKAY);
    // the live count leaves 7f after some tens of cycles
    for (int i = 0; i < 100; i++) begin
      rdr(IDX_RATE_HIGH, RESP_OKAY, d);
      if (d == 8'h7e) break;
    end
    chk("counter high", 8'h7e, d);
  endtask

  task automatic t_link7();
    lstep(1'b1, 1'b0, 1'b0, 5'h01);
    lrun(5'h19, 7);
    lrun(5'h0f, 1);
    lrun(5'h0e, 1);
    lrun(5'h02, 1);
    @(posedge link_clk);
    stop_cnt <= 1'b1;
    hold_scl <= 1'b1;
    repeat (10) @(posedge link_clk);
    rchk(IDX_BUS_STATE, 8'h62, "observe");
    lrun(5'h03, 8);
    lstep(1'b0, 1'b1, 1'b0, 5'h0c);
    lrun(5'h0d, 1);
    lrun(5'h00, 1);
    @(posedge link_clk);
    stop_cnt <= 1'b0;
    hold_scl <= 1'b0;
    hold_sda <= 1'b1;
    repeat (10) @(posedge link_clk);
    rchk(IDX_BUS_STATE, 8'h80, "observe");
    wr(IDX_BUS_STATE, 8'h00, 4'hf, RESP_OKAY);
    rchk(IDX_BUS_STATE, 8'h80, "observe kept");
  endtask

  task automatic t_link10();
    @(posedge link_clk);
    ten_bit <= 1'b1;
    hold_sda <= 1'b0;
    lstep(1'b1, 1'b0, 1'b0, 5'h01);
    lrun(5'h10, 8);
    lrun(5'h18, 1);
    lrun(5'h19, 7);
    lrun(5'h0f, 1);
    lrun(5'h0e, 1);
    lrun(5'h02, 9);
    lstep(1'b0, 1'b0, 1'b1, 5'h0b);
    lrun(5'h0c, 2);
    lrun(5'h00, 1);
    // a refused 7-bit address goes straight to the stop pair
    @(posedge link_clk);
    ten_bit <= 1'b0;
    lstep(1'b1, 1'b0, 1'b0, 5'h01);
    lrun(5'h19, 7);
    lrun(5'h0f, 1);
    lrun(5'h0e, 1);
    lstep(1'b0, 1'b0, 1'b1, 5'h0c);
    lrun(5'h0d, 1);
    lrun(5'h00, 1);
  endtask

  // reset both domains, release link_reset_n first and reset_n one clk edge later, then run the scenarios
  initial begin
    {reset_n, link_reset_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {hold_scl, hold_sda, step, start, stop, nack, ten_bit, stop_cnt} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    ce = 1'b1;
    bad_count = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    repeat (3) @(posedge link_clk);
    link_reset_n <= 1'b1;
    @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_rate();
    t_counter_readback_select();
    t_link7();
    t_link10();
    summarize();
  end
endmodule
